// File: hdl/rst_seq_pkg.sv
// Constants and carrier types for the hardware reset sequencer
package rst_seq_pkg;
  // Clock and half-period arithmetic
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;
  // Half-clock-period counts of the sequence
  localparam int START_MIN_HCP = 4;
  localparam int START_MAX_HCP = 16;
  localparam int SEQ_LEN_HCP = 1024;
  localparam int END_MIN_HCP = 4;
  localparam int END_MAX_HCP = 6;
  localparam int ALE_DELAY_HCP = 8;
  // Least external reset pulse, checked by the board only
  localparam int ASYNC_LOW_NS = 1500;
  localparam int CNT_W = 11;
  // Chosen delays inside the documented windows
  localparam logic [CNT_W-1:0] START_DLY = 11'h004;
  localparam logic [CNT_W-1:0] SEQ_LEN = 11'h400;
  localparam logic [CNT_W-1:0] END_DLY = 11'h004;
  localparam logic [CNT_W-1:0] ALE_DLY = 11'h008;
  localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;
  localparam logic [CNT_W-1:0] CNT_STEP = 11'h002;
  // Configuration port field positions
  localparam int CFG_EMU_BIT = 0;
  localparam int CFG_SELECT_BIT_A_BIT = 1;
  localparam int CFG_CLK_LSB = 13;
  localparam int CFG_CLK_MSB = 15;
  localparam int CFG_W = 16;
  localparam int ADDR_W = 24;
  localparam logic [ADDR_W-1:0] START_ADDR = 24'h000000;
  // Latched start-up configuration
  typedef struct packed {
    logic emulation_select_bit;
    logic select_bit_a;
    logic [2:0] clk_cfg;
  } startup_cfg_t;
  localparam startup_cfg_t CFG_RESET = 5'h1F;
  // Sequencer states
  typedef enum logic [5:0] {
    S_RUN = 6'h01,
    S_ENTRY = 6'h02,
    S_SEQ = 6'h04,
    S_WAIT_HIGH = 6'h08,
    S_END_DLY = 6'h10,
    S_ALE_DLY = 6'h20
  } seq_state_t;
endpackage : rst_seq_pkg

// File: hdl/pin_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
  parameter logic INIT = 1'b1
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic pin, // Asynchronous pin level
  output logic level // Filtered level
);
  logic [2:0] sh_r;
  logic [2:0] sh_nxt;
  logic level_r;
  logic level_nxt;

  // Stage one feeds only stage two; stages two and three vote
  always_comb begin
    sh_nxt = {sh_r[1:0], pin};
    level_nxt = (sh_r[1] == sh_r[2]) ? sh_r[2] : level_r;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sh_r <= {3{INIT}};
      level_r <= INIT;
    end else begin
      sh_r <= sh_nxt;
      level_r <= level_nxt;
    end
  end

  assign level = level_r;
endmodule : pin_sync3
`default_nettype wire

// File: hdl/hw_reset_sequencer.sv
// Hardware reset sequencer: reset entry, start-up latch, strobe release
`timescale 1ns/1ps
`default_nettype none

module hw_reset_sequencer
  import rst_seq_pkg::*;
(
  input wire logic CLK, // System clock, 20 MHz
  input wire logic RST_N, // Synchronous reset, active low
  input wire logic RESET_IN_N_I, // Reset pin level in
  output logic RESET_IN_N_O, // Reset pin drive value
  output logic RESET_IN_N_OE, // Reset pin drive enable
  input wire logic [CFG_W-1:0] CONFIG_PORT, // Configuration port pins
  output logic CONFIG_PULLUP_EN, // Pull-ups on configuration port
  input wire logic END_INIT_INSTRUCTION, // Pulse: end-of-init executed
  input wire logic IO_ACTIVATE, // Pulse: software enables I/O
  output logic IO_ENABLE, // General I/O active
  output logic RESET_OUT_N, // Reset output, active low
  output logic INTERNAL_RESET, // Internal reset condition
  output startup_cfg_t STARTUP_CFG, // Latched start-up configuration
  output logic ALE_ENABLE, // Strobe released, high = may toggle
  output logic FETCH_START, // Pulse: begin fetching
  output logic [ADDR_W-1:0] FETCH_ADDR // First fetch address
);
  logic pin_lvl;
  logic pin_prev_r;
  logic pin_prev_nxt;
  seq_state_t state_r;
  seq_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic drive_r;
  logic drive_nxt;
  logic irst_r;
  logic irst_nxt;
  logic pull_r;
  logic pull_nxt;
  logic rout_n_r;
  logic rout_n_nxt;
  logic ale_r;
  logic ale_nxt;
  logic fetch_r;
  logic fetch_nxt;
  logic io_r;
  logic io_nxt;
  startup_cfg_t cfg_r;
  startup_cfg_t cfg_nxt;
  // Registered copies of the fixed pin value and first fetch address
  logic pin_o_r;
  logic pin_o_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic fall;

  // Reset pin is off-domain, so it goes through the voting synchroniser
  pin_sync3 #(
    .INIT(1'b1)
  ) u_rst_pin (
    .clk(CLK),
    .rst_n(RST_N),
    .pin(RESET_IN_N_I),
    .level(pin_lvl)
  );

  // Falling edge on the filtered pin; the rise is used as a level
  assign fall = pin_prev_r & ~pin_lvl;

  // Sequencer: one system clock is two half periods, counter steps by 2
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    drive_nxt = drive_r;
    irst_nxt = irst_r;
    pull_nxt = pull_r;
    rout_n_nxt = rout_n_r;
    ale_nxt = ale_r;
    fetch_nxt = 1'b0;
    io_nxt = io_r;
    cfg_nxt = cfg_r;
    pin_prev_nxt = pin_lvl;
    // Open drain: the pin is only ever pulled low
    pin_o_nxt = 1'b0;
    addr_nxt = START_ADDR;
    unique case (state_r)
      S_RUN: begin
        if (fall) begin
          // Default state taken at once on entry
          state_nxt = S_ENTRY;
          cnt_nxt = CNT_STEP;
          irst_nxt = 1'b1;
          pull_nxt = 1'b1;
          rout_n_nxt = 1'b0;
          ale_nxt = 1'b0;
          io_nxt = 1'b0;
        end
      end
      S_ENTRY: begin
        if (cnt_r >= START_DLY) begin
          state_nxt = S_SEQ;
          cnt_nxt = CNT_STEP;
          drive_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r + CNT_STEP;
        end
      end
      S_SEQ: begin
        if (cnt_r >= SEQ_LEN) begin
          state_nxt = S_WAIT_HIGH;
          drive_nxt = 1'b0;
        end else begin
          cnt_nxt = cnt_r + CNT_STEP;
        end
      end
      S_WAIT_HIGH: begin
        // Own drive just released; wait for the board to let go
        if (pin_lvl) begin
          state_nxt = S_END_DLY;
          cnt_nxt = CNT_STEP;
        end
      end
      S_END_DLY: begin
        if (!pin_lvl) begin
          state_nxt = S_WAIT_HIGH;
        end else if (cnt_r >= END_DLY) begin
          state_nxt = S_ALE_DLY;
          cnt_nxt = CNT_STEP;
          irst_nxt = 1'b0;
          pull_nxt = 1'b0;
        end else begin
          cnt_nxt = cnt_r + CNT_STEP;
        end
      end
      S_ALE_DLY: begin
        if (cnt_r >= ALE_DLY) begin
          state_nxt = S_RUN;
          cnt_nxt = CNT_ZERO;
          ale_nxt = 1'b1;
          fetch_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r + CNT_STEP;
        end
      end
      default: begin
        state_nxt = S_RUN;
      end
    endcase
    // Configuration follows the port for as long as reset is held
    if (irst_r) begin
      cfg_nxt.emulation_select_bit = CONFIG_PORT[CFG_EMU_BIT];
      cfg_nxt.select_bit_a = CONFIG_PORT[CFG_SELECT_BIT_A_BIT];
      cfg_nxt.clk_cfg = CONFIG_PORT[CFG_CLK_MSB:CFG_CLK_LSB];
    end
    // Reset output released only by end-of-init; a new entry wins
    if (!irst_r && state_r == S_RUN && END_INIT_INSTRUCTION && !fall) begin
      rout_n_nxt = 1'b1;
    end
    // No automatic activation of general I/O
    if (!irst_r && IO_ACTIVATE && !(state_r == S_RUN && fall)) begin
      io_nxt = 1'b1;
    end
  end

  // Register stage; power-on state is the default reset state
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_r <= S_SEQ;
      cnt_r <= CNT_STEP;
      drive_r <= 1'b1;
      irst_r <= 1'b1;
      pull_r <= 1'b1;
      rout_n_r <= 1'b0;
      ale_r <= 1'b0;
      fetch_r <= 1'b0;
      io_r <= 1'b0;
      cfg_r <= CFG_RESET;
      pin_prev_r <= 1'b1;
      pin_o_r <= 1'b0;
      addr_r <= START_ADDR;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      drive_r <= drive_nxt;
      irst_r <= irst_nxt;
      pull_r <= pull_nxt;
      rout_n_r <= rout_n_nxt;
      ale_r <= ale_nxt;
      fetch_r <= fetch_nxt;
      io_r <= io_nxt;
      cfg_r <= cfg_nxt;
      pin_prev_r <= pin_prev_nxt;
      pin_o_r <= pin_o_nxt;
      addr_r <= addr_nxt;
    end
  end

  // Outputs straight from flip-flops; open-drain pin drives low only
  assign RESET_IN_N_O = pin_o_r;
  assign RESET_IN_N_OE = drive_r;
  assign CONFIG_PULLUP_EN = pull_r;
  assign IO_ENABLE = io_r;
  assign RESET_OUT_N = rout_n_r;
  assign INTERNAL_RESET = irst_r;
  assign STARTUP_CFG = cfg_r;
  assign ALE_ENABLE = ale_r;
  assign FETCH_START = fetch_r;
  assign FETCH_ADDR = addr_r;
endmodule : hw_reset_sequencer
`default_nettype wire

// File: test/board_reset_model.sv
// Board model: reset switch, pin pull-up, configuration pull-downs
`timescale 1ns/1ps
`default_nettype none
module board_reset_model (
  input wire logic hold_low, // Switch pulls pin
  input wire logic dev_oe, // Device drive enable
  input wire logic dev_o, // Device drive value
  input wire logic pu_en, // Device pull-ups on
  input wire logic [15:0] pd_mask, // Lines tied low
  output logic pin, // Resolved pin
  output logic [15:0] cfg // Resolved config lines
);
  // Open drain with board pull-up: low while anyone pulls
  assign pin = !(hold_low || (dev_oe && !dev_o));
  // Open lines float once pull-ups go off, so all lines read low
  assign cfg = pu_en ? ~pd_mask : 16'h0000;
endmodule : board_reset_model
`default_nettype wire

// File: test/rst_seq_monitor.sv
// Port checker for the hardware reset sequencer
`timescale 1ns/1ps
`default_nettype none
module rst_seq_monitor
  import rst_seq_pkg::*;
(
  input wire logic CLK, // Clock
  input wire logic RST_N, // Reset
  input wire logic RESET_IN_N_I, // Pin
  input wire logic RESET_IN_N_O, // Pin value
  input wire logic RESET_IN_N_OE, // Pin enable
  input wire logic [CFG_W-1:0] CONFIG_PORT, // Config
  input wire logic END_INIT_INSTRUCTION, // End-init
  input wire logic IO_ACTIVATE, // I/O request
  input wire logic IO_ENABLE, // I/O on
  input wire logic RESET_OUT_N, // Reset out
  input wire logic INTERNAL_RESET, // Internal reset
  input wire startup_cfg_t STARTUP_CFG, // Latched config
  input wire logic ALE_ENABLE, // Strobe on
  input wire logic FETCH_START, // Fetch pulse
  input wire logic [ADDR_W-1:0] FETCH_ADDR // Fetch address
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [10:0] hi_r, hi_nxt;
  logic por_r, por_nxt;
  // Pin drive length; the run begun by reset is skipped
  always_comb begin
    hi_nxt = RESET_IN_N_OE ? hi_r + 11'h001 : 11'h000;
    por_nxt = por_r && RESET_IN_N_OE;
  end
  always_ff @(posedge CLK) begin
    hi_r <= RST_N ? hi_nxt : 11'h000;
    por_r <= RST_N ? por_nxt : 1'b1;
  end
  seq_start_a: assert property (
    $fell(RESET_IN_N_I) && ALE_ENABLE && !INTERNAL_RESET
    |-> ##[2:8] $rose(RESET_IN_N_OE)) else $error("late start");
  seq_len_a: assert property (
    $fell(RESET_IN_N_OE) && !por_r |-> hi_r == 11'h400 >> 1)
    else $error("sequence length");
  // Pin filter adds four edges ahead of the end delay; short pulses skip
  end_delay_a: assert property (
    $rose(RESET_IN_N_I) && INTERNAL_RESET && !RESET_IN_N_OE
    ##1 RESET_IN_N_I [*6] |-> ##1 $fell(INTERNAL_RESET))
    else $error("reset end");
  ale_delay_a: assert property (
    $fell(INTERNAL_RESET) |-> !ALE_ENABLE [*4] ##1 ALE_ENABLE)
    else $error("strobe delay");
  fetch_start_a: assert property (
    $rose(ALE_ENABLE) |-> FETCH_START && FETCH_ADDR == 24'h000000
    ##1 !FETCH_START) else $error("fetch start");
  cfg_load_a: assert property (
    INTERNAL_RESET ##1 INTERNAL_RESET |-> STARTUP_CFG ==
    {$past(CONFIG_PORT[0]), $past(CONFIG_PORT[1]),
    $past(CONFIG_PORT[15:13])}) else $error("config load");
  pin_drive_a: assert property (
    RESET_IN_N_OE |-> !RESET_IN_N_O && INTERNAL_RESET)
    else $error("pin drive");
  warm_hold_a: assert property (
    INTERNAL_RESET && !RESET_IN_N_I |=> INTERNAL_RESET)
    else $error("early end");
  rst_out_a: assert property (
    $rose(RESET_OUT_N) |-> $past(END_INIT_INSTRUCTION) &&
    !INTERNAL_RESET) else $error("reset out");
  io_release_a: assert property (
    $rose(IO_ENABLE) |-> $past(IO_ACTIVATE)) else $error("io");
endmodule : rst_seq_monitor
bind hw_reset_sequencer rst_seq_monitor u_rst_seq_monitor (.*);
`default_nettype wire

// File: test/hardware_reset_sequencer_tb.sv
// Testbench: board resets, start-up config, end-init, I/O release
`timescale 1ns/1ps
`default_nettype none
module hardware_reset_sequencer_tb;
  logic clk = 1'b0, rst_n = 1'b0, hold = 1'b1, eini = 1'b0;
  logic ioa = 1'b0, pin, o, oe, pu, io, ro, ir, ale, fs;
  logic [15:0] pd = 16'h4001, cfg;
  logic [4:0] sc;
  logic [23:0] fa;
  int bad_count = 0, cmp_count = 0, i, n;
  board_reset_model u_board_reset_model (.hold_low(hold),
    .dev_oe(oe), .dev_o(o), .pu_en(pu), .pd_mask(pd), .pin(pin),
    .cfg(cfg));
  hw_reset_sequencer u_hw_reset_sequencer (.CLK(clk), .RST_N(rst_n),
    .RESET_IN_N_I(pin), .RESET_IN_N_O(o), .RESET_IN_N_OE(oe),
    .CONFIG_PORT(cfg), .CONFIG_PULLUP_EN(pu),
    .END_INIT_INSTRUCTION(eini), .IO_ACTIVATE(ioa), .IO_ENABLE(io),
    .RESET_OUT_N(ro), .INTERNAL_RESET(ir), .STARTUP_CFG(sc),
    .ALE_ENABLE(ale), .FETCH_START(fs), .FETCH_ADDR(fa));
  initial forever #25 clk = ~clk;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask : chk
  // Bounded wait, since a stuck sequence must not hang the run
  task wait_end;
    for (i = 0; i < 2000 && ir !== 1'b0; i++) @(negedge clk);
    chk(ir, 1'b0);
    chk(pu, 1'b0);
    repeat (3) @(negedge clk);
    chk({ale, fs}, 2'b00);
    @(negedge clk);
    chk({ale, fs, fa}, 26'h3000000);
  endtask : wait_end
  task t_power;
    repeat (40) @(negedge clk);
    chk(cfg, 16'hBFFE);
    hold = 1'b0;
    wait_end;
    chk({sc, ro, io}, 7'h34);
    $display("power-up test done");
  endtask : t_power
  task t_warm;
    pd = 16'h2002;
    hold = 1'b1;
    for (i = 0; i < 20 && oe !== 1'b1; i++) @(negedge clk);
    chk(i >= 2 && i <= 8, 1'b1);
    for (n = 0; n < 600 && oe === 1'b1; n++) @(negedge clk);
    chk(n, 512);
    repeat (40) @(negedge clk);
    chk(ir, 1'b1);
    // Short high pulse must send the sequencer back to waiting
    hold = 1'b0;
    repeat (2) @(negedge clk);
    hold = 1'b1;
    repeat (12) @(negedge clk);
    chk(ir, 1'b1);
    hold = 1'b0;
    wait_end;
    chk({sc, ro, io}, 7'h58);
    $display("warm reset test done");
  endtask : t_warm
  task t_end_init_instruction;
    chk({ro, io}, 2'b00);
    eini = 1'b1;
    @(negedge clk);
    eini = 1'b0;
    repeat (2) @(negedge clk);
    chk({ro, io}, 2'b10);
    ioa = 1'b1;
    @(negedge clk);
    ioa = 1'b0;
    repeat (2) @(negedge clk);
    chk(io, 1'b1);
    $display("end-init test done");
  endtask : t_end_init_instruction
  task t_default;
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk({ir, ro, ale, io, pu, oe}, 6'h23);
    rst_n = 1'b1;
    wait_end;
    $display("default entry test done");
  endtask : t_default
  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    t_power;
    t_end_init_instruction;
    t_warm;
    t_default;
    end_of_test;
  end
  // Watchdog: about three times the expected run
  initial begin
    #(5000 * 50);
    bad_count++;
    end_of_test;
  end
endmodule : hardware_reset_sequencer_tb
`default_nettype wire
